// >>> scgc_periph_model.sv
// Model of the gated peripheral registers at the far side of the controller
// Assumes accesses arrive through the design's gated write strobe
module scgc_periph_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] periph_clk_en,
  input wire logic periph_write_en,
  input wire logic periph_sel_valid,
  input wire logic [2:0] periph_index,
  output logic [7:0] periph_rdata_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // One write counter per peripheral
  // ----------------------------------------
  logic [7:0] cnt [8];
  logic [7:0] last;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= '{default: 8'h00};
      last <= 8'h00;
    end else begin
      if (periph_write_en && periph_clk_en[periph_index]) begin
        cnt[periph_index] <= cnt[periph_index] + 8'h01;
      end
      if (periph_sel_valid) begin
        last <= cnt[periph_index];
      end
    end
  end
  // Not selected: inverse of the last value
  assign periph_rdata_in = periph_sel_valid ? cnt[periph_index] : ~last;
endmodule : scgc_periph_model

// >>> scgc_pkg.sv
// Package for the sleep and clock gating controller
// Assumes a single 100 MHz clock and an APB register bus
package scgc_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] SCGC_SLEEP_CTRL_OFS = 12'h000;
  localparam logic [11:0] SCGC_PPR_OFS = 12'h004;
  localparam logic [11:0] SCGC_CONFIG_OFS = 12'h008;
  localparam logic [11:0] SCGC_STATUS_OFS = 12'h00c;
  localparam logic [7:0] SCGC_PPR_RESET = 8'h00;
  localparam logic [7:0] SCGC_PPR_WMASK = 8'hef;
  localparam logic [3:0] SCGC_SLEEP_CTRL_RESET = 4'h0;
  localparam logic [5:0] SCGC_CONFIG_RESET = 6'h00;

  // ----------------------------------------
  // Gating bit positions
  // ----------------------------------------
  localparam int SCGC_BIT_TWI = 7;
  localparam int SCGC_BIT_TIM2 = 6;
  localparam int SCGC_BIT_TIM0 = 5;
  localparam int SCGC_BIT_RES = 4;
  localparam int SCGC_BIT_TIM1 = 3;
  localparam int SCGC_BIT_SPI = 2;
  localparam int SCGC_BIT_USART = 1;
  localparam int SCGC_BIT_CONV = 0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SCGC_CLK_MHZ = 100;
  localparam logic [3:0] SCGC_STANDBY_WAKE_CYC = 4'h6;
  localparam logic [3:0] SCGC_HALT_EXTRA_CYC = 4'h4;
  localparam logic [15:0] SCGC_STARTUP_RESET = 16'h0010;

  // ----------------------------------------
  // Sleep modes and controller states
  // ----------------------------------------
  typedef enum logic [2:0] {
    SCGC_MODE_IDLE = 3'b000,
    SCGC_MODE_NOISE = 3'b001,
    SCGC_MODE_PDOWN = 3'b010,
    SCGC_MODE_PSAVE = 3'b011,
    SCGC_MODE_R4 = 3'b100,
    SCGC_MODE_R5 = 3'b101,
    SCGC_MODE_STANDBY = 3'b110,
    SCGC_MODE_R7 = 3'b111
  } scgc_mode_t;

  typedef enum logic [1:0] {
    SCGC_ST_ACTIVE = 2'b00,
    SCGC_ST_SLEEP = 2'b01,
    SCGC_ST_START = 2'b10,
    SCGC_ST_HALT = 2'b11
  } scgc_state_t;

  // Wake requests from the system
  typedef struct packed {
    logic ext_level;
    logic ext_edge;
    logic pin_change;
    logic addr_match;
    logic timer_two;
    logic store_ready;
    logic converter;
    logic watchdog;
    logic other_io;
  } scgc_wake_t;

  // Analog and fuse status from the system
  typedef struct packed {
    logic converter_on;
    logic comparator_on;
    logic comparator_uses_ref;
    logic brownout_fuse_on;
    logic watchdog_on;
    logic crystal_selected;
  } scgc_analog_t;

  // Clock and power enables to the system
  typedef struct packed {
    logic core_clock_domain;
    logic program_memory_clock;
    logic peripheral_clock_domain;
    logic converter_clock_domain;
    logic separate_oscillator_clock;
    logic main_source_en;
    logic timer_osc_en;
    logic converter_en;
    logic comparator_en;
    logic reference_en;
    logic brownout_en;
    logic watchdog_en;
    logic input_buffers_en;
    logic extended_conversion;
    logic comparator_mux_block;
  } scgc_power_t;

  typedef struct packed {
    scgc_state_t state;
    scgc_mode_t mode;
    logic [3:0] sleep_ctrl;
    logic [7:0] ppr;
    logic [5:0] config_bits;
    logic [15:0] count;
    logic [31:0] prdata;
    logic conv_was_on;
    logic ext_conv;
    logic woke;
  } scgc_regs_t;

endpackage : scgc_pkg

// >>> scgc_top.sv
// Sleep mode and per-peripheral clock gating controller
// Assumes core sleep pulse, wake sources and status are synchronous to clk
// Notes on behaviour
// - Code 110 with crystal enters standby
// - Standby wakes after six clock cycles
// - Clock domains stopped per sleep mode
// - Wake sources accepted per sleep mode
// - Deep modes wake on level or pin-change pins, never on edge pins
// - Timer oscillator runs only in async mode
// - Gating bit stops clock, blocks register access
// - Clearing gate resumes frozen state
// - Gating acts in every state, timer two included in power-save
// - Gating bit layout, cleared at reset
// - Bit four reads zero, not writable
// - Timer two gate only when synchronous
// - Converter stays on; restart gives extended conversion
// - Deep modes disable comparator unless reference used
// - Reference on only when something needs it
// - Fuse-enabled brown-out stays on in sleep
// - Enabled watchdog keeps running in sleep
// - Input buffers off when both clocks stop
// - Mode select encodings, others reserved
// - Core held four cycles past start-up
module scgc_top #(
  parameter logic [15:0] STARTUP_CYCLES = scgc_pkg::SCGC_STARTUP_RESET
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_instr,
  input wire scgc_pkg::scgc_wake_t wake_req,
  input wire scgc_pkg::scgc_analog_t analog_in,
  input wire logic timer_two_external_clock_sel,
  input wire logic periph_sel_valid,
  input wire logic periph_write,
  input wire logic [2:0] periph_index,
  input wire logic [7:0] periph_rdata_in,
  output logic periph_write_en,
  output logic [7:0] periph_rdata,
  output logic [7:0] periph_clk_en,
  output scgc_pkg::scgc_power_t power,
  output logic core_hold,
  output logic sleeping
);
  import scgc_pkg::*;

  scgc_regs_t r;
  scgc_regs_t next_r;
  logic deep;
  logic wake_ok;
  logic [7:0] gate_eff;
  logic wr;
  logic rd;
  logic asleep;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic mode_valid(input scgc_mode_t m, input logic xtal);
    unique case (m)
      SCGC_MODE_IDLE, SCGC_MODE_NOISE, SCGC_MODE_PDOWN, SCGC_MODE_PSAVE: mode_valid = 1'b1;
      SCGC_MODE_STANDBY: mode_valid = xtal;
      default: mode_valid = 1'b0;
    endcase
  endfunction : mode_valid

  function automatic logic wake_allowed(input scgc_mode_t m, input scgc_wake_t w);
    logic pins;
    pins = w.ext_level | w.pin_change;
    unique case (m)
      SCGC_MODE_IDLE: wake_allowed = |w;
      SCGC_MODE_NOISE: wake_allowed = pins | w.addr_match | w.timer_two | w.store_ready
        | w.converter | w.watchdog;
      SCGC_MODE_PSAVE: wake_allowed = pins | w.addr_match | w.timer_two | w.watchdog;
      default: wake_allowed = pins | w.addr_match | w.watchdog;
    endcase
  endfunction : wake_allowed

  assign asleep = (r.state == SCGC_ST_SLEEP) || (r.state == SCGC_ST_START);
  assign deep = asleep && (r.mode != SCGC_MODE_IDLE);
  assign wake_ok = wake_allowed(r.mode, wake_req);
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    next_r.prdata = r.prdata;
    if (wr) begin
      unique case (paddr)
        SCGC_SLEEP_CTRL_OFS: next_r.sleep_ctrl = pwdata[3:0];
        SCGC_PPR_OFS: next_r.ppr = pwdata[7:0] & SCGC_PPR_WMASK;
        SCGC_CONFIG_OFS: next_r.config_bits = pwdata[5:0];
        default: ;
      endcase
    end
    if (rd) begin
      unique case (paddr)
        SCGC_SLEEP_CTRL_OFS: next_r.prdata = {28'h0000000, r.sleep_ctrl};
        SCGC_PPR_OFS: next_r.prdata = {24'h000000, r.ppr & SCGC_PPR_WMASK};
        SCGC_CONFIG_OFS: next_r.prdata = {26'h0000000, r.config_bits};
        SCGC_STATUS_OFS: next_r.prdata = {25'h0000000, r.woke, r.ext_conv, r.mode, r.state};
        default: next_r.prdata = 32'h00000000;
      endcase
    end
    unique case (r.state)
      SCGC_ST_ACTIVE: begin
        if (sleep_instr && r.sleep_ctrl[0]
            && mode_valid(scgc_mode_t'(r.sleep_ctrl[3:1]), analog_in.crystal_selected)) begin
          next_r.state = SCGC_ST_SLEEP;
          next_r.mode = scgc_mode_t'(r.sleep_ctrl[3:1]);
          next_r.woke = 1'b0;
        end
      end
      SCGC_ST_SLEEP: begin
        if (wake_ok) begin
          next_r.state = SCGC_ST_START;
          next_r.woke = 1'b1;
          if (r.mode == SCGC_MODE_STANDBY) begin
            next_r.count = {12'h000, SCGC_STANDBY_WAKE_CYC} - 16'h0001;
          end else if (r.mode == SCGC_MODE_IDLE || r.mode == SCGC_MODE_NOISE) begin
            next_r.count = 16'h0000;
          end else begin
            next_r.count = STARTUP_CYCLES - 16'h0001;
          end
        end
      end
      SCGC_ST_START: begin
        if (r.count == 16'h0000) begin
          next_r.state = SCGC_ST_HALT;
          next_r.count = {12'h000, SCGC_HALT_EXTRA_CYC} - 16'h0001;
        end else begin
          next_r.count = r.count - 16'h0001;
        end
      end
      SCGC_ST_HALT: begin
        if (r.count == 16'h0000) begin
          next_r.state = SCGC_ST_ACTIVE;
        end else begin
          next_r.count = r.count - 16'h0001;
        end
      end
    endcase
    next_r.conv_was_on = analog_in.converter_on;
    if (!analog_in.converter_on) begin
      next_r.ext_conv = r.conv_was_on ? 1'b1 : r.ext_conv;
    end else if (r.config_bits[0]) begin
      next_r.ext_conv = 1'b0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '{state: SCGC_ST_ACTIVE, mode: SCGC_MODE_IDLE, sleep_ctrl: SCGC_SLEEP_CTRL_RESET,
             ppr: SCGC_PPR_RESET, config_bits: SCGC_CONFIG_RESET, count: 16'h0000,
             prdata: 32'h00000000, conv_was_on: 1'b0, ext_conv: 1'b0, woke: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Clock and power outputs
  // ----------------------------------------
  always_comb begin
    logic io_run;
    logic adc_run;
    io_run = !asleep || r.mode == SCGC_MODE_IDLE;
    adc_run = io_run || r.mode == SCGC_MODE_NOISE;
    power.core_clock_domain = !asleep;
    power.program_memory_clock = !asleep;
    power.peripheral_clock_domain = io_run;
    power.converter_clock_domain = adc_run;
    power.separate_oscillator_clock = adc_run || r.mode == SCGC_MODE_PSAVE;
    power.main_source_en = adc_run || r.mode == SCGC_MODE_STANDBY
      || r.state == SCGC_ST_START;
    power.timer_osc_en = timer_two_external_clock_sel
      && (adc_run || r.mode == SCGC_MODE_PSAVE);
    power.converter_en = analog_in.converter_on;
    power.comparator_en = analog_in.comparator_on
      && (!deep || r.mode == SCGC_MODE_NOISE || analog_in.comparator_uses_ref);
    power.brownout_en = analog_in.brownout_fuse_on;
    power.reference_en = power.brownout_en || power.converter_en
      || (power.comparator_en && analog_in.comparator_uses_ref);
    power.watchdog_en = analog_in.watchdog_on;
    power.input_buffers_en = io_run || adc_run;
    power.extended_conversion = r.ext_conv;
    power.comparator_mux_block = r.ppr[SCGC_BIT_CONV];
  end

  // Peripheral gating
  always_comb begin
    gate_eff = r.ppr & SCGC_PPR_WMASK;
    gate_eff[SCGC_BIT_TIM2] = r.ppr[SCGC_BIT_TIM2] && !timer_two_external_clock_sel;
    for (int i = 0; i < 8; i++) begin
      periph_clk_en[i] = power.peripheral_clock_domain && !gate_eff[i];
    end
    periph_clk_en[SCGC_BIT_TIM2] = !gate_eff[SCGC_BIT_TIM2]
      && (power.peripheral_clock_domain || timer_two_external_clock_sel
          || (asleep && r.mode == SCGC_MODE_PSAVE));
    periph_clk_en[SCGC_BIT_RES] = 1'b0;
  end

  assign periph_write_en = periph_sel_valid && periph_write && !gate_eff[periph_index];
  assign periph_rdata = gate_eff[periph_index] ? 8'h00 : periph_rdata_in;
  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign core_hold = r.state != SCGC_ST_ACTIVE;
  assign sleeping = asleep;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_STANDBY_SIX: assert property (
    (r.state == SCGC_ST_SLEEP && r.mode == SCGC_MODE_STANDBY && wake_ok)
      |=> (r.state == SCGC_ST_START) [*6] ##1 r.state == SCGC_ST_HALT)
    else $error("Standby wake not six cycles");
  AST_HALT_FOUR: assert property (
    $rose(r.state == SCGC_ST_HALT) |-> (r.state == SCGC_ST_HALT) [*4] ##1 !core_hold)
    else $error("Halt not four cycles");
  AST_CORE_STOP: assert property (
    sleeping |-> !power.core_clock_domain && !power.program_memory_clock)
    else $error("Core clock runs in sleep");
  AST_STANDBY_MAIN: assert property (
    (sleeping && r.mode == SCGC_MODE_STANDBY) |-> power.main_source_en
      && !power.peripheral_clock_domain)
    else $error("Standby clocks wrong");
  AST_PDOWN_EDGE: assert property (
    (r.state == SCGC_ST_SLEEP && r.mode == SCGC_MODE_PDOWN && wake_req == 9'h080)
      |=> r.state == SCGC_ST_SLEEP)
    else $error("Edge woke deep sleep");
  AST_GATE_WRITE: assert property (
    (periph_sel_valid && gate_eff[periph_index]) |-> !periph_write_en && periph_rdata == 8'h00)
    else $error("Gated peripheral accessed");
  AST_RES_ZERO: assert property (
    $past(rd && paddr == SCGC_PPR_OFS) |-> prdata[SCGC_BIT_RES] == 1'b0)
    else $error("Reserved bit reads one");
  AST_TIM2_ASYNC: assert property (
    timer_two_external_clock_sel |-> !gate_eff[SCGC_BIT_TIM2])
    else $error("Async timer two gated");
  AST_BUF_OFF: assert property (
    (!power.peripheral_clock_domain && !power.converter_clock_domain) |-> !power.input_buffers_en)
    else $error("Input buffers on");
  AST_REF: assert property (
    power.reference_en |-> (analog_in.brownout_fuse_on || analog_in.converter_on
      || analog_in.comparator_on))
    else $error("Reference on without user");

  COV_IDLE: cover property (r.state == SCGC_ST_SLEEP && r.mode == SCGC_MODE_IDLE ##1 wake_ok);
  COV_STANDBY: cover property (r.state == SCGC_ST_SLEEP && r.mode == SCGC_MODE_STANDBY);
  COV_PSAVE_WAKE: cover property (r.mode == SCGC_MODE_PSAVE && $rose(r.state == SCGC_ST_START));
  COV_GATED: cover property (periph_sel_valid && gate_eff[periph_index]);

endmodule : scgc_top

// >>> tb_top.sv
// Self-checking bench for the sleep and clock gating controller
// Assumes APB with pready answers and a peripheral model on the far side
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import scgc_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic sleep_instr = 1'b0;
  scgc_wake_t wake_req = '0;
  scgc_analog_t analog_in = 6'h17;
  logic t2_async = 1'b0;
  logic p_sel = 1'b0;
  logic p_wr = 1'b0;
  logic [2:0] p_idx = 3'h0;
  logic [7:0] p_rin;
  logic p_we;
  logic [7:0] p_rd;
  logic [7:0] clk_en;
  scgc_power_t power;
  logic core_hold;
  logic sleeping;
  int err_total = 0;
  int n_tests = 0;
  logic [31:0] d;
  always #5 clk = ~clk;
  scgc_top #(.STARTUP_CYCLES(16'h0002)) uut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .sleep_instr(sleep_instr), .wake_req(wake_req),
    .analog_in(analog_in), .timer_two_external_clock_sel(t2_async),
    .periph_sel_valid(p_sel), .periph_write(p_wr), .periph_index(p_idx),
    .periph_rdata_in(p_rin), .periph_write_en(p_we), .periph_rdata(p_rd),
    .periph_clk_en(clk_en), .power(power), .core_hold(core_hold), .sleeping(sleeping));
  scgc_periph_model model (.clk(clk), .rst_n(rst_n), .periph_clk_en(clk_en),
    .periph_write_en(p_we), .periph_sel_valid(p_sel), .periph_index(p_idx),
    .periph_rdata_in(p_rin));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    d = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      err_total++;
      print_verdict();
    end
  endtask : apb
  task pacc(input logic w, input logic [2:0] i, input logic we, input logic [7:0] rd);
    @(posedge clk);
    p_sel <= 1'b1;
    p_wr <= w;
    p_idx <= i;
    #1;
    check("periph_write_en", p_we, we);
    check("periph_rdata", p_rd, rd);
    @(posedge clk);
    p_sel <= 1'b0;
    p_wr <= 1'b0;
  endtask : pacc
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task regs_case;
    apb(1'b0, SCGC_PPR_OFS, 32'h0);
    check("gating reset", d, 32'h0);
    apb(1'b1, SCGC_PPR_OFS, 32'hff);
    apb(1'b0, SCGC_PPR_OFS, 32'h0);
    check("gating readback", d, 32'hef);
    check("clk_en all gated", clk_en, 8'h00);
    apb(1'b1, SCGC_PPR_OFS, 32'h40);
    #1 check("clk_en t2 sync", clk_en, 8'haf);
    t2_async <= 1'b1;
    #1 check("clk_en t2 async", clk_en, 8'hef);
    t2_async <= 1'b0;
    apb(1'b0, 12'h0f0, 32'h0);
    check("unmapped read", d, 32'h0);
  endtask : regs_case
  task gate_case;
    apb(1'b1, SCGC_PPR_OFS, 32'h0);
    pacc(1'b1, 3'h2, 1'b1, 8'h00);
    pacc(1'b1, 3'h2, 1'b1, 8'h01);
    apb(1'b1, SCGC_PPR_OFS, 32'h05);
    pacc(1'b1, 3'h2, 1'b0, 8'h00);
    #1 check("mux block", power.comparator_mux_block, 1'b1);
    apb(1'b1, SCGC_PPR_OFS, 32'h0);
    pacc(1'b0, 3'h2, 1'b0, 8'h02);
    analog_in.converter_on <= 1'b1;
    @(posedge clk);
    analog_in.converter_on <= 1'b0;
    repeat (2) @(posedge clk);
    check("extended conv", power.extended_conversion, 1'b1);
  endtask : gate_case
  task sleep_case(input logic [3:0] ctrl, input scgc_wake_t bad, input scgc_wake_t good,
                  input int cyc, input logic [4:0] clks, input logic main);
    int k;
    logic deep;
    deep = (ctrl[3:1] != 3'b000) && (ctrl[3:1] != 3'b001);
    apb(1'b1, SCGC_SLEEP_CTRL_OFS, {28'h0, ctrl});
    @(posedge clk);
    sleep_instr <= 1'b1;
    @(posedge clk);
    sleep_instr <= 1'b0;
    #1 check("sleeping", sleeping, 1'b1);
    check("clock domains", {power.core_clock_domain, power.program_memory_clock,
      power.peripheral_clock_domain, power.converter_clock_domain,
      power.separate_oscillator_clock}, clks);
    check("main source", power.main_source_en, main);
    check("input buffers", power.input_buffers_en, clks[2] | clks[1]);
    check("comparator", power.comparator_en, !deep);
    check("reference", power.reference_en, 1'b1);
    check("brownout", power.brownout_en, 1'b1);
    check("watchdog", power.watchdog_en, 1'b1);
    if (deep) check("deep clk_en", clk_en, (ctrl[3:1] == 3'b011) ? 8'h40 : 8'h00);
    if (bad != '0) begin
      wake_req <= bad;
      repeat (3) @(posedge clk);
      wake_req <= '0;
      #1 check("not woken", sleeping, 1'b1);
    end
    @(posedge clk);
    wake_req <= good;
    k = 0;
    do begin
      @(posedge clk);
      wake_req <= '0;
      #1;
      k++;
    end while (core_hold !== 1'b0 && k < 40);
    check("wake cycles", k, cyc);
  endtask : sleep_case
  task reserved_case;
    logic [3:0] codes [4];
    codes = '{4'h9, 4'hb, 4'hf, 4'h4};
    foreach (codes[i]) begin
      apb(1'b1, SCGC_SLEEP_CTRL_OFS, {28'h0, codes[i]});
      @(posedge clk);
      sleep_instr <= 1'b1;
      @(posedge clk);
      sleep_instr <= 1'b0;
      #1 check("refused sleep", sleeping, 1'b0);
    end
  endtask : reserved_case
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    regs_case();
    gate_case();
    sleep_case(4'h1, '0, 9'h001, 6, 5'b00111, 1'b1);
    sleep_case(4'h3, 9'h001, 9'h004, 6, 5'b00011, 1'b1);
    sleep_case(4'h5, 9'h080, 9'h100, 7, 5'b00000, 1'b0);
    sleep_case(4'h7, 9'h080, 9'h010, 7, 5'b00001, 1'b0);
    sleep_case(4'hd, 9'h080, 9'h040, 11, 5'b00000, 1'b1);
    reserved_case();
    print_verdict();
  end
endmodule : tb_top
